// ---- ext_int_map.vh ----
// register offsets, field positions and reset values for the external interrupt latch
`ifndef EXT_INT_MAP_VH
`define EXT_INT_MAP_VH
`define ADDR_W            4
`define DATA_W            8
`define OFF_STATUS_CTRL   4'h0
`define OFF_BREAK_CTRL    4'h1
`define OFF_IRQ_STATUS    4'h2
`define OFF_IRQ_MASK      4'h3
`define BIT_MODE          0
`define BIT_MASK          1
`define BIT_ACK           2
`define BIT_PEND          3
`define BIT_BREAK_CLEAR_ENABLE          7
`define EV_LATCH          0
`define EV_ACK            1
`define EV_W              2
`define RST_STATUS_CTRL   8'h00
`define RST_BREAK_CTRL    8'h00
`define VEC_HI_ADDR       16'hFFFA
`define VEC_LO_ADDR       16'hFFFB
`endif

// ---- pin_edge_sync.v ----
// two-stage pin synchroniser with falling edge detect
`timescale 1ns/1ps
module pin_edge_sync (
  // clock and reset
  input  wire clk,
  input  wire nrst,
  // pin and results
  input  wire pinIn,
  output reg  pinLevel_ff,
  output wire fallEdge
);
  reg       meta_ff;
  reg       prev_ff;
  reg [1:0] warm_ff;
  // flops reset high, idle level of the pin
  always @(posedge clk) begin
    if (!nrst) begin
      meta_ff     <= 1'b1;
      pinLevel_ff <= 1'b1;
      prev_ff     <= 1'b1;
    end else begin
      meta_ff     <= pinIn;
      pinLevel_ff <= meta_ff;
      prev_ff     <= pinLevel_ff;
    end
  end
  // edges count only once both samples are real, so a pin held low through reset raises nothing
  // limitation: a fall in the first cycles after reset is not latched
  always @(posedge clk) begin
    if (!nrst) begin
      warm_ff <= 2'b00;
    end else if (warm_ff != 2'b11) begin
      warm_ff <= warm_ff + 2'b01;
    end
  end
  assign fallEdge = (warm_ff == 2'b11) & prev_ff & ~pinLevel_ff;
endmodule

// ---- external_interrupt_latch.v ----
// external interrupt latch with status/control register and event interrupt
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "ext_int_map.vh"
// Operation
// - a falling edge on the low-active pin sets the latch in both modes.
// - a vector fetch of this source acknowledges and clears its latch.
// - writing 1 to the acknowledge bit clears the latch.
// - reset clears latch, mode bit and mask bit even with pin low.
// - edge-only mode: latch holds until acknowledge, then clears at once.
// - edge-plus-level mode: request stays while pin low; needs acknowledge and high.
// - mode bit 1 means edges and low level, 0 means edges only.
// - mask bit 1 keeps the latched request from the priority logic.
// - pending flag shows latch state, regardless of the mask.
// - acknowledge bit is write-only, reads 0, cleared by reset.
// - acknowledge does not stop later edges from latching fresh requests.
// - with mask clear, the CPU takes the vector from the two assigned locations.
// - in break state with break clear-enable 0, acknowledge writes do nothing.
// - a latch cleared during break stays cleared after break.
// - the pin level is offered to the two pin-level branch instructions.
module external_interrupt_latch (
  // clock and reset
  input  wire                 clk,
  input  wire                 nrst,
  // register port
  input  wire [`ADDR_W-1:0]   addr,
  input  wire [`DATA_W-1:0]   wrData,
  input  wire                 wrEn,
  input  wire                 rdEn,
  output reg  [`DATA_W-1:0]   rdData_ff,
  // external pin, active low
  input  wire                 extIntPinN,
  // cpu side
  input  wire                 vectorFetch,
  input  wire                 breakState,
  output reg                  cpuIrqReq_ff,
  output reg  [15:0]          vectorAddr_ff,
  output reg                  branchPinHigh_ff,
  output reg                  branchPinLow_ff,
  // event interrupt
  output reg                  irq_ff
);
  // one-hot states of the request latch
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_HELD  = 3'b010;
  localparam [2:0] ST_ACKED = 3'b100;
  // reset images of the two control registers
  localparam [`DATA_W-1:0] RST_SC = `RST_STATUS_CTRL;
  localparam [`DATA_W-1:0] RST_BC = `RST_BREAK_CTRL;

  // synchroniser results
  wire                 pinLevel;
  wire                 fallEdge;
  // request latch
  reg  [2:0]           state_ff;
  reg  [2:0]           nxt_state;
  wire                 latched;
  wire                 pending;
  // control bits
  reg                  mode_ff;
  reg                  nxt_mode;
  reg                  mask_ff;
  reg                  nxt_mask;
  reg                  breakClrEn_ff;
  reg                  nxt_breakClrEn;
  // event status and mask
  reg  [`EV_W-1:0]     evStat_ff;
  wire [`EV_W-1:0]     nxt_evStat;
  reg  [`EV_W-1:0]     evMask_ff;
  reg  [`EV_W-1:0]     nxt_evMask;
  wire [`EV_W-1:0]     evIn;
  // register port decode
  wire                 selStatusCtrl;
  wire                 selBreakCtrl;
  wire                 selIrqStatus;
  wire                 selIrqMask;
  wire                 wrStatusCtrl;
  wire                 wrBreakCtrl;
  wire                 wrIrqMask;
  wire                 rdIrqStatus;
  reg  [`DATA_W-1:0]   nxt_rdData;
  // acknowledge paths
  wire                 ackWrite;
  wire                 swAck;
  wire                 anyAck;
  // next values of the cpu side outputs
  reg                  nxt_cpuIrqReq;
  reg                  nxt_irq;
  reg  [15:0]          nxt_vectorAddr;
  reg                  nxt_branchPinHigh;
  reg                  nxt_branchPinLow;
  genvar               gi;

  // pin synchroniser and falling edge detector
  pin_edge_sync u_sync (
    .clk         (clk),
    .nrst        (nrst),
    .pinIn       (extIntPinN),
    .pinLevel_ff (pinLevel),
    .fallEdge    (fallEdge)
  );

  // address match, used by every register select
  function hit;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  // true while the latch holds a request, acknowledged or not
  function isLatched;
    input [2:0] st;
    begin
      isLatched = (st == ST_HELD) | (st == ST_ACKED);
    end
  endfunction

  // register selects
  assign selStatusCtrl = hit(addr, `OFF_STATUS_CTRL);
  assign selBreakCtrl  = hit(addr, `OFF_BREAK_CTRL);
  assign selIrqStatus  = hit(addr, `OFF_IRQ_STATUS);
  assign selIrqMask    = hit(addr, `OFF_IRQ_MASK);
  assign wrStatusCtrl  = wrEn & selStatusCtrl;
  assign wrBreakCtrl   = wrEn & selBreakCtrl;
  assign wrIrqMask     = wrEn & selIrqMask;
  assign rdIrqStatus   = rdEn & selIrqStatus;

  // acknowledge sources
  assign ackWrite = wrStatusCtrl & wrData[`BIT_ACK];
  // break protection gates only software; a vector fetch cannot happen in break
  assign swAck    = ackWrite & (~breakState | breakClrEn_ff);
  assign anyAck   = swAck | vectorFetch;

  // pending ignores the mask so polling software can use it
  assign latched = isLatched(state_ff);
  assign pending = latched;

  // request latch; an edge beats a clear in the same cycle so no event is lost
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_state = ST_IDLE;
      end
      ST_HELD: begin
        if (mode_ff) begin
          if (anyAck & pinLevel) begin
            nxt_state = ST_IDLE;
          end else if (anyAck) begin
            nxt_state = ST_ACKED;
          end
        end else if (anyAck) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_ACKED: begin
        // leaving level mode while acked drops the remembered acknowledge
        if (mode_ff & pinLevel) begin
          nxt_state = ST_IDLE;
        end else if (!mode_ff) begin
          nxt_state = anyAck ? ST_IDLE : ST_HELD;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (fallEdge) begin
      nxt_state = ST_HELD;
    end
  end

  // control bits; mode and mask are written even when a break blocks the acknowledge
  always @* begin
    nxt_mode       = mode_ff;
    nxt_mask       = mask_ff;
    nxt_breakClrEn = breakClrEn_ff;
    nxt_evMask     = evMask_ff;
    if (wrStatusCtrl) begin
      nxt_mode = wrData[`BIT_MODE];
      nxt_mask = wrData[`BIT_MASK];
    end
    if (wrBreakCtrl) begin
      nxt_breakClrEn = wrData[`BIT_BREAK_CLEAR_ENABLE];
    end
    if (wrIrqMask) begin
      nxt_evMask = wrData[`EV_W-1:0];
    end
  end

  // event sources
  assign evIn[`EV_LATCH] = fallEdge;
  assign evIn[`EV_ACK]   = anyAck & latched;

  // sticky event bits; a new event beats the clearing read so nothing is lost
  generate
    for (gi = 0; gi < `EV_W; gi = gi + 1) begin : g_ev
      assign nxt_evStat[gi] = evIn[gi] | (evStat_ff[gi] & ~rdIrqStatus);
    end
  endgenerate

  // read mux; unmapped offsets read as zero
  always @* begin
    nxt_rdData = {`DATA_W{1'b0}};
    case (addr)
      `OFF_STATUS_CTRL: begin
        nxt_rdData[`BIT_MODE] = mode_ff;
        nxt_rdData[`BIT_MASK] = mask_ff;
        nxt_rdData[`BIT_ACK]  = 1'b0;
        nxt_rdData[`BIT_PEND] = pending;
      end
      `OFF_BREAK_CTRL: begin
        nxt_rdData[`BIT_BREAK_CLEAR_ENABLE] = breakClrEn_ff;
      end
      `OFF_IRQ_STATUS: begin
        nxt_rdData[`EV_W-1:0] = evStat_ff;
      end
      `OFF_IRQ_MASK: begin
        nxt_rdData[`EV_W-1:0] = evMask_ff;
      end
      default: begin
        nxt_rdData = {`DATA_W{1'b0}};
      end
    endcase
    if (!rdEn) begin
      nxt_rdData = {`DATA_W{1'b0}};
    end
  end

  // next values of the cpu side outputs, all registered
  always @* begin
    nxt_cpuIrqReq     = isLatched(nxt_state) & ~mask_ff;
    nxt_irq           = |(nxt_evStat & evMask_ff);
    nxt_vectorAddr    = `VEC_HI_ADDR;
    nxt_branchPinHigh = pinLevel;
    nxt_branchPinLow  = ~pinLevel;
  end

  // request latch; a clear made in break persists since nothing restores it
  always @(posedge clk) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // sensitivity select
  always @(posedge clk) begin
    if (!nrst) begin
      mode_ff <= RST_SC[`BIT_MODE];
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // request mask
  always @(posedge clk) begin
    if (!nrst) begin
      mask_ff <= RST_SC[`BIT_MASK];
    end else begin
      mask_ff <= nxt_mask;
    end
  end

  // break clear enable
  always @(posedge clk) begin
    if (!nrst) begin
      breakClrEn_ff <= RST_BC[`BIT_BREAK_CLEAR_ENABLE];
    end else begin
      breakClrEn_ff <= nxt_breakClrEn;
    end
  end

  // event mask
  always @(posedge clk) begin
    if (!nrst) begin
      evMask_ff <= {`EV_W{1'b0}};
    end else begin
      evMask_ff <= nxt_evMask;
    end
  end

  // event status
  always @(posedge clk) begin
    if (!nrst) begin
      evStat_ff <= {`EV_W{1'b0}};
    end else begin
      evStat_ff <= nxt_evStat;
    end
  end

  // read data stands only in the cycle after the read strobe
  always @(posedge clk) begin
    if (!nrst) begin
      rdData_ff <= {`DATA_W{1'b0}};
    end else begin
      rdData_ff <= nxt_rdData;
    end
  end

  // request to the priority logic
  always @(posedge clk) begin
    if (!nrst) begin
      cpuIrqReq_ff <= 1'b0;
    end else begin
      cpuIrqReq_ff <= nxt_cpuIrqReq;
    end
  end

  // event interrupt line
  always @(posedge clk) begin
    if (!nrst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  // vector location of this source
  always @(posedge clk) begin
    if (!nrst) begin
      vectorAddr_ff <= `VEC_HI_ADDR;
    end else begin
      vectorAddr_ff <= nxt_vectorAddr;
    end
  end

  // pin level for the branch instructions; reset shows the pin idle high
  always @(posedge clk) begin
    if (!nrst) begin
      branchPinHigh_ff <= 1'b1;
      branchPinLow_ff  <= 1'b0;
    end else begin
      branchPinHigh_ff <= nxt_branchPinHigh;
      branchPinLow_ff  <= nxt_branchPinLow;
    end
  end
endmodule

// ---- ext_int_chk_properties.sv ----
// port checker for the external interrupt latch
`timescale 1ns/1ps
module ext_int_chk (
  // clock and reset
  input logic        clk,
  input logic        nrst,
  // register port
  input logic [3:0]  addr,
  input logic [7:0]  wrData,
  input logic        wrEn,
  input logic        rdEn,
  input logic [7:0]  rdData_ff,
  // pin and cpu side
  input logic        extIntPinN,
  input logic        vectorFetch,
  input logic        cpuIrqReq_ff,
  input logic [15:0] vectorAddr_ff,
  input logic        branchPinHigh_ff,
  input logic        branchPinLow_ff,
  input logic        irq_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_reset_clears_req: assert property ($rose(nrst) |-> !cpuIrqReq_ff && !irq_ff && rdData_ff == 8'h00)
    else $error("request live after reset");
  a_fetch_clears_req: assert property (extIntPinN [*4] ##0 vectorFetch |=> !cpuIrqReq_ff)
    else $error("vector fetch left request set");
  // two cycles, since the request register updates one edge after the mask lands on the strobe edge
  a_mask_blocks_req: assert property (wrEn && addr == 4'h0 && wrData[1] ##1 !(wrEn && addr == 4'h0)
    |=> !cpuIrqReq_ff)
    else $error("masked request reached priority logic");
  a_ack_reads_zero: assert property (rdEn && addr == 4'h0 |=> !rdData_ff[2])
    else $error("acknowledge bit read as one");
  a_unmapped_reads_zero: assert property (rdEn && addr > 4'h3 |=> rdData_ff == 8'h00)
    else $error("unmapped read not zero");
  a_idle_data_zero: assert property (!rdEn |=> rdData_ff == 8'h00)
    else $error("read data outside read cycle");
  a_vector_fixed: assert property (vectorAddr_ff == 16'hFFFA)
    else $error("vector address wrong");
  a_branch_pins_apart: assert property (branchPinHigh_ff != branchPinLow_ff)
    else $error("branch pin levels agree");
endmodule
bind external_interrupt_latch ext_int_chk u_chk (.clk(clk), .nrst(nrst), .addr(addr), .wrData(wrData),
  .wrEn(wrEn), .rdEn(rdEn), .rdData_ff(rdData_ff), .extIntPinN(extIntPinN), .vectorFetch(vectorFetch),
  .cpuIrqReq_ff(cpuIrqReq_ff), .vectorAddr_ff(vectorAddr_ff), .branchPinHigh_ff(branchPinHigh_ff),
  .branchPinLow_ff(branchPinLow_ff), .irq_ff(irq_ff));

// ---- ext_pin_source.sv ----
// external interrupt source driving the pin
`timescale 1ns/1ps
module ext_pin_source (
  // clock
  input  logic clk,
  // active-low pin
  output logic pinN
);
  // idles high as the pullup holds it
  initial pinN = 1'b1;
  // hold long enough for the two-flop sync to pass the level
  task set(input logic v);
    @(posedge clk) pinN <= v;
    repeat (4) @(posedge clk);
    #1;
  endtask
endmodule

// ---- testbench.sv ----
// self-checking bench for the external interrupt latch
`timescale 1ns/1ps
module testbench;
  logic        clk = 0, nrst = 0, wrEn = 0, rdEn = 0, fetch = 0, brk = 0;
  logic [3:0]  addr = 0;
  logic [7:0]  wrData = 0, rdData;
  logic [15:0] vAddr;
  logic        pinN, req, bHi, bLo, irq;
  int          n_errors = 0, num_checks = 0;
  always #4 clk = ~clk;
  ext_pin_source src (.clk(clk), .pinN(pinN));
  external_interrupt_latch DUT (.clk(clk), .nrst(nrst), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
    .rdData_ff(rdData), .extIntPinN(pinN), .vectorFetch(fetch), .breakState(brk), .cpuIrqReq_ff(req),
    .vectorAddr_ff(vAddr), .branchPinHigh_ff(bHi), .branchPinLow_ff(bLo), .irq_ff(irq));
  task chk(string s, logic [7:0] e, logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  task wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk) {wrEn, addr, wrData} <= {1'b1, a, d};
    @(posedge clk) wrEn <= 0;
  endtask
  task rd(logic [3:0] a, logic [7:0] e);
    @(posedge clk) {rdEn, addr} <= {1'b1, a};
    @(posedge clk) rdEn <= 0;
    #1 chk($sformatf("reg%0h", a), e, rdData);
  endtask
  task pulse_fetch;
    @(posedge clk) fetch <= 1;
    @(posedge clk) fetch <= 0;
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    wrap_up;
  end
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1;
    rd(0, 8'h00);
    rd(1, 8'h00);
    rd(4'hF, 8'h00);
    chk("vec", 1, vAddr === 16'hFFFA);
    wr(3, 8'h01);
    src.set(0);
    chk("req", 1, req);
    chk("lo", 1, bLo);
    chk("hi", 0, bHi);
    chk("irq", 1, irq);
    rd(0, 8'h08);
    rd(2, 8'h01);
    @(posedge clk) #1 chk("irq", 0, irq);
    wr(0, 8'h04);
    rd(0, 8'h00);
    src.set(1);
    wr(0, 8'h02);
    src.set(0);
    chk("req", 0, req);
    rd(0, 8'h0A);
    pulse_fetch;
    rd(0, 8'h02);
    src.set(1);
    // level mode with mask set: an acknowledge with the pin low keeps the latch pending until the pin goes high
    wr(0, 8'h03);
    src.set(0);
    src.set(1);
    rd(0, 8'h0B);
    pulse_fetch;
    rd(0, 8'h03);
    src.set(0);
    rd(0, 8'h0B);
    wr(0, 8'h07);
    rd(0, 8'h0B);
    src.set(1);
    rd(0, 8'h03);
    wr(0, 8'h00);
    src.set(0);
    @(posedge clk) brk <= 1;
    wr(0, 8'h04);
    rd(0, 8'h08);
    wr(1, 8'h80);
    wr(0, 8'h04);
    @(posedge clk) brk <= 0;
    rd(0, 8'h00);
    rd(1, 8'h80);
    wr(0, 8'h03);
    src.set(1);
    src.set(0);
    rd(0, 8'h0B);
    @(posedge clk) nrst <= 0;
    repeat (2) @(posedge clk);
    nrst <= 1;
    repeat (4) @(posedge clk);
    rd(0, 8'h00);
    chk("req", 0, req);
    src.set(1);
    wrap_up;
  end
endmodule
